// ---- src/ubrg_pkg.sv ----
// shared constants for the uart bit rate generator
package ubrg_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_DIV_HI = 5'h00;
  localparam logic [4:0] OFS_DIV_LO = 5'h04;
  localparam logic [4:0] OFS_CTRL2 = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
  localparam logic [4:0] OFS_GEN_STAT = 5'h14;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_GAP_IRQ_ON = 7;
  localparam int BIT_EDGE_IRQ_ON = 6;
  localparam int BIT_RCV_ON = 2;
  localparam int BIT_XMIT_ON = 3;
  localparam int BIT_ST_GAP = 0;
  localparam int BIT_ST_EDGE = 1;
  localparam int BIT_ST_TICK = 2;
  localparam int DIV_HI_BITS = 5;
  localparam int DIV_BITS = 13;
  localparam int OVERSAMPLE = 16;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DIV_HI = 8'h00;
  localparam logic [7:0] RST_DIV_LO = 8'h04;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // ---------------------------------------------------------------
  // axi responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ubrg_pkg

// ---- src/ubrg_edge_sync.sv ----
// two flop synchroniser with rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module ubrg_edge_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;

  // first flop only feeds the second
  always_comb begin
    s1_nxt = async_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign rise = s2_r & ~s3_r;
endmodule : ubrg_edge_sync
`default_nettype wire

// ---- src/ubrg_divider.sv ----
// modulo divider producing the oversample tick
`timescale 1ns/1ps
`default_nettype none
module ubrg_divider #(
  parameter int DW = 13
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [DW-1:0] divisor,
  output logic tick
);
  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // counter frozen at zero when stopped, so nothing toggles
  // zero divisor stops the counter
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run || divisor == '0) begin
      cnt_nxt = '0;
    end else if (cnt_r >= divisor - DW'(1)) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + DW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : ubrg_divider
`default_nettype wire

// ---- src/ubrg_top.sv ----
// bit rate generator with divisor registers and axi4-lite slave
// Behaviour
// - one generator per port, shared tx/rx
// - six registers in the port, at most 8 bits wide
// - hi[4:0] write buffered until low write; hi[7:6] act at once
// - hi[4:0] and lo[7:0] form divisor
// - idle after reset until enable written
// - zero divisor stops the generator
// - bit rate is clock over sixteen divisor
// - hi bit 7 gates sync gap flag
// - hi bit 6 gates rx edge flag
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ubrg_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lin_sync_gap_in,
  input wire logic rx_pin_edge_in,
  output logic os_tick,
  output logic irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] divHi_r, divHi_nxt;
  logic [4:0] hiBuf_r, hiBuf_nxt;
  logic [7:0] divLo_r, divLo_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic started_r, started_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic awHeld_r, awHeld_nxt;
  logic [4:0] awAddr_r, awAddr_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [7:0] wData_r, wData_nxt;
  logic wStrb_r, wStrb_nxt;
  logic bValid_r, bValid_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  logic rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0] rResp_r, rResp_nxt;
  logic awReady_r, awReady_nxt;
  logic wReady_r, wReady_nxt;
  logic arReady_r, arReady_nxt;
  logic gapRise, edgeRise, tickRaw, tick_r;
  logic [12:0] divisorValue;
  logic doWrite, doRead;

  // ---------------------------------------------------------------
  // address check, shared by both paths
  // ---------------------------------------------------------------
  function automatic logic addr_ok(input logic [4:0] a);
    addr_ok = (a == ubrg_pkg::OFS_DIV_HI) || (a == ubrg_pkg::OFS_DIV_LO) ||
              (a == ubrg_pkg::OFS_CTRL2) || (a == ubrg_pkg::OFS_IRQ_STAT) ||
              (a == ubrg_pkg::OFS_IRQ_MASK) || (a == ubrg_pkg::OFS_GEN_STAT);
  endfunction : addr_ok

  // ---------------------------------------------------------------
  // flag inputs cross from pins
  // ---------------------------------------------------------------
  // pulses shorter than one clock may slip past the synchroniser
  ubrg_edge_sync u_gap (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(lin_sync_gap_in),
    .rise(gapRise)
  );
  ubrg_edge_sync u_edge (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(rx_pin_edge_in),
    .rise(edgeRise)
  );

  // ---------------------------------------------------------------
  // divisor and generator
  // ---------------------------------------------------------------
  // divisor concatenation
  assign divisorValue = {divHi_r[ubrg_pkg::DIV_HI_BITS-1:0], divLo_r};

  // one tick stream serves both shifters, so they never drift apart
  // single generator feeds tx and rx
  // bus clock over sixteen times divisor
  ubrg_divider #(.DW(ubrg_pkg::DIV_BITS)) u_div (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(started_r),
    .divisor(divisorValue),
    .tick(tickRaw)
  );

  // ---------------------------------------------------------------
  // axi handshakes: accept aw and w in any order
  // ---------------------------------------------------------------
  // next response held off until the last one is taken
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign doRead = s_axi_arvalid && s_axi_arready;

  // next values for both channels; reads decode the live address
  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata[7:0];
      wStrb_nxt = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      // unmapped offsets answer with an error and change nothing
      bResp_nxt = addr_ok(awAddr_r) ? ubrg_pkg::RESP_OKAY : ubrg_pkg::RESP_SLVERR;
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (doRead) begin
      rValid_nxt = 1'b1;
      rResp_nxt = addr_ok(s_axi_araddr) ? ubrg_pkg::RESP_OKAY : ubrg_pkg::RESP_SLVERR;
      rData_nxt = 32'h0000_0000;
      if (s_axi_araddr == ubrg_pkg::OFS_DIV_HI) begin
        rData_nxt[7:0] = divHi_r;
      end else if (s_axi_araddr == ubrg_pkg::OFS_DIV_LO) begin
        rData_nxt[7:0] = divLo_r;
      end else if (s_axi_araddr == ubrg_pkg::OFS_CTRL2) begin
        rData_nxt[7:0] = ctrl2_r;
      end else if (s_axi_araddr == ubrg_pkg::OFS_IRQ_STAT) begin
        rData_nxt[2:0] = stat_r;
      end else if (s_axi_araddr == ubrg_pkg::OFS_IRQ_MASK) begin
        rData_nxt[2:0] = mask_r;
      end else if (s_axi_araddr == ubrg_pkg::OFS_GEN_STAT) begin
        // reports stopped while the divisor is zero
        rData_nxt[0] = started_r && (divisorValue != 13'h0000);
      end
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // ready flags
  // ---------------------------------------------------------------
  // readies stay low while an answer waits, so no second request
  // can slip in behind an unacknowledged response
  // registered so the ready pins come straight from flops
  always_comb begin
    awReady_nxt = !awHeld_nxt && !bValid_nxt;
    wReady_nxt = !wHeld_nxt && !bValid_nxt;
    arReady_nxt = !rValid_nxt;
  end

  // ---------------------------------------------------------------
  // register file and interrupt logic
  // ---------------------------------------------------------------
  // next register values; flag sets are applied last
  always_comb begin
    divHi_nxt = divHi_r;
    hiBuf_nxt = hiBuf_r;
    divLo_nxt = divLo_r;
    ctrl2_nxt = ctrl2_r;
    started_nxt = started_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (doWrite && wStrb_r) begin
      if (awAddr_r == ubrg_pkg::OFS_DIV_HI) begin
        hiBuf_nxt = wData_r[4:0];
        // enable bits act at once, unlike the divisor half
        divHi_nxt[7:6] = wData_r[7:6];
      end else if (awAddr_r == ubrg_pkg::OFS_DIV_LO) begin
        // low write commits buffered high half
        divLo_nxt = wData_r;
        divHi_nxt[4:0] = hiBuf_r;
      end else if (awAddr_r == ubrg_pkg::OFS_CTRL2) begin
        ctrl2_nxt = wData_r;
        // first enable write starts generator
        // latched for good: only reset clears it again
        if (wData_r[ubrg_pkg::BIT_RCV_ON] || wData_r[ubrg_pkg::BIT_XMIT_ON]) begin
          started_nxt = 1'b1;
        end
      end else if (awAddr_r == ubrg_pkg::OFS_IRQ_STAT) begin
        // write one to clear; a same-cycle set below still wins
        stat_nxt = stat_r & ~wData_r[2:0];
      end else if (awAddr_r == ubrg_pkg::OFS_IRQ_MASK) begin
        // mask shares the status layout
        mask_nxt = wData_r[2:0];
      end
    end
    // set wins over a same-cycle clear
    if (gapRise) begin
      stat_nxt[ubrg_pkg::BIT_ST_GAP] = 1'b1;
    end
    if (edgeRise) begin
      stat_nxt[ubrg_pkg::BIT_ST_EDGE] = 1'b1;
    end
    if (tickRaw) begin
      stat_nxt[ubrg_pkg::BIT_ST_TICK] = 1'b1;
    end
    // gap flag gated by hi bit 7
    // edge flag gated by hi bit 6
    // tick flag has no enable bit: the mask alone gates it
    irq_nxt = |(stat_r & mask_r & {1'b1, divHi_r[ubrg_pkg::BIT_EDGE_IRQ_ON],
                                   divHi_r[ubrg_pkg::BIT_GAP_IRQ_ON]});
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      divHi_r <= ubrg_pkg::RST_DIV_HI;
      hiBuf_r <= 5'h00;
      divLo_r <= ubrg_pkg::RST_DIV_LO;
      ctrl2_r <= ubrg_pkg::RST_CTRL2;
      started_r <= 1'b0;
      stat_r <= ubrg_pkg::RST_IRQ;
      mask_r <= ubrg_pkg::RST_IRQ;
      irq_r <= 1'b0;
      tick_r <= 1'b0;
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      arReady_r <= 1'b1;
      awHeld_r <= 1'b0;
      awAddr_r <= 5'h00;
      wHeld_r <= 1'b0;
      wData_r <= 8'h00;
      wStrb_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= 2'h0;
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= 2'h0;
    end else begin
      divHi_r <= divHi_nxt;
      hiBuf_r <= hiBuf_nxt;
      divLo_r <= divLo_nxt;
      ctrl2_r <= ctrl2_nxt;
      started_r <= started_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      tick_r <= tickRaw;
      awReady_r <= awReady_nxt;
      wReady_r <= wReady_nxt;
      arReady_r <= arReady_nxt;
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs: each port is a plain copy of a flop
  // ---------------------------------------------------------------
  // no gates here, so no glitch or long path reaches the pins
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign os_tick = tick_r;
  assign irq = irq_r;
endmodule : ubrg_top
`default_nettype wire

// ---- verification/ubrg_top_checker.sv ----
// port checks for the bit rate generator
`timescale 1ns/1ps
`default_nettype none
module ubrg_top_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic os_tick,
  input wire logic irq
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_rst_quiet;
    $fell(sys_rst) |-> !os_tick && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read taken");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("second write taken");
  property p_r_width;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_r_width: assert property (p_r_width) else $error("wide read data");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  // main scenarios seen
  c_tick: cover property (os_tick);
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : ubrg_top_checker
bind ubrg_top ubrg_top_checker chk (.*);
`default_nettype wire

// ---- verification/ubrg_serial_peer.sv ----
// remote serial side driving the sync gap and rx edge pins
`timescale 1ns/1ps
`default_nettype none
module ubrg_serial_peer (
  input wire logic clock,
  output logic gapPin,
  output logic edgePin
);
  // pins rest low between events
  initial begin
    gapPin = 1'b0;
    edgePin = 1'b0;
  end
  // long len mimics a slow peer holding the line
  task automatic pulse(input logic sel, input int len);
    @(posedge clock);
    if (sel) edgePin <= 1'b1;
    else gapPin <= 1'b1;
    repeat (len) @(posedge clock);
    gapPin <= 1'b0;
    edgePin <= 1'b0;
  endtask : pulse
endmodule : ubrg_serial_peer
`default_nettype wire

// ---- verification/test_uart_baud_rate_generator.sv ----
// self-checking bench for the bit rate generator
`timescale 1ns/1ps
`default_nettype none
module test_uart_baud_rate_generator;
  logic clock, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, os_tick, irq;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic lin_sync_gap_in, rx_pin_edge_in;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  ubrg_top DUT (.*);
  ubrg_serial_peer peer (.clock(clock), .gapPin(lin_sync_gap_in), .edgePin(rx_pin_edge_in));
  // ----------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // extra edge at the end so the next call never re-drives in one step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : rd
  // clocks from one tick to the next
  task automatic period(input int exp);
    int n;
    n = 0;
    do @(posedge clock); while (os_tick !== 1'b1);
    do begin
      @(posedge clock);
      n++;
    end while (os_tick !== 1'b1);
    chk(32'(n), 32'(exp));
  endtask : period
  task automatic quiet(input int len);
    repeat (len) begin
      @(posedge clock);
      chk({31'h0, os_tick}, 32'h0);
    end
  endtask : quiet
  task automatic irq_after(input logic exp);
    repeat (10) @(posedge clock);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_after
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(5'h00);
    chk(data, 32'h0);
    rd(5'h04);
    chk(data, 32'h4);
    rd(5'h14);
    chk(data, 32'h0);
    rd(5'h18);
    chk({data[29:0], resp}, 32'h2);
    wr(5'h18, 8'hff);
    chk({30'h0, resp}, 32'h2);
    s_axi_wstrb <= 4'h0;
    wr(5'h04, 8'h55);
    s_axi_wstrb <= 4'h1;
    rd(5'h04);
    chk(data, 32'h4);
    quiet(40);
  endtask : t_reset
  task automatic t_rate();
    wr(5'h04, 8'h03);
    wr(5'h08, 8'h04);
    period(3);
    rd(5'h14);
    chk(data, 32'h1);
    rd(5'h0c);
    chk(data & 32'h4, 32'h4);
    wr(5'h00, 8'h01);
    rd(5'h00);
    chk(data, 32'h0);
    period(3);
    wr(5'h04, 8'h00);
    period(256);
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h00);
    rd(5'h14);
    chk(data, 32'h0);
    quiet(300);
  endtask : t_rate
  task automatic t_irq();
    wr(5'h10, 8'h03);
    wr(5'h00, 8'hc0);
    rd(5'h00);
    chk(data, 32'hc0);
    wr(5'h0c, 8'h07);
    peer.pulse(1'b0, 2);
    irq_after(1'b1);
    wr(5'h0c, 8'h01);
    irq_after(1'b0);
    wr(5'h00, 8'h40);
    peer.pulse(1'b0, 6);
    irq_after(1'b0);
    rd(5'h0c);
    chk(data & 32'h3, 32'h1);
    wr(5'h0c, 8'h01);
    wr(5'h10, 8'h00);
    peer.pulse(1'b1, 2);
    irq_after(1'b0);
    wr(5'h10, 8'h02);
    irq_after(1'b1);
    wr(5'h0c, 8'h02);
    irq_after(1'b0);
  endtask : t_irq
  initial begin
    sys_rst = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_rate();
    t_irq();
    stop_test();
  end
endmodule : test_uart_baud_rate_generator
`default_nettype wire
